// [bench/host_model.sv]
// Host side model: APB master and enable source of the sequencer.
// Assumes a free-running pclk; the bench calls its tasks by hierarchy.
module host_model
  import ssr_pkg::*;
(
  input wire logic pclk,
  input wire ssr_pkg::apb_rsp_t apb_rsp,
  output ssr_pkg::apb_req_t apb_req,
  output logic en_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    apb_req = '0;
    en_in = 1'b0;
  end
  // Enable only from a low output, never after a high precharge
  task automatic set_en(input logic v);
    @(posedge pclk);
    en_in <= v;
  endtask
  // Boot override goes in after the bias wait, before enable
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic err);
    @(posedge pclk);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    // No limit of its own; the bench watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (apb_rsp.pready !== 1'b1);
    r = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    // Released lines show the inverse, so stale values never pass
    apb_req <= '{1'b0, 1'b0, ~w, ~a, ~d};
  endtask
endmodule

// [bench/testbench.sv]
// Self-checking bench of the soft-start ramp sequencer.
// Assumes host_model drives APB and enable; counts shortened by params.
module testbench;
  import ssr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIAS = 50;
  localparam int DLY = 20;
  localparam int DIV = 256;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  apb_req_t apb_req;
  apb_rsp_t apb_rsp;
  logic en_in;
  logic [7:0] boot_strap = 8'h01;
  logic [7:0] ramp_strap = 8'h1F;
  code_t pre = '0;
  code_t dac_code;
  logic gate_drive_oe;
  logic power_good_flag;
  logic gain_multiplier_select;
  logic [1:0] loop_impedance_select;
  int num_errors = 0;
  int checks_done = 0;
  logic [31:0] rd;
  logic err;

  always #2 pclk = ~pclk;

  soft_start_ramp_sequencer #(.BIAS_CYC(BIAS), .DELAY_CYC(DLY),
    .SLEW_DIV(DIV)) soft_start_ramp_sequencer_i (
    .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .en_in(en_in), .boot_voltage_strap(boot_strap),
    .ramp_config_strap(ramp_strap), .precharge_code(pre),
    .dac_code(dac_code), .gate_drive_oe(gate_drive_oe),
    .power_good_flag(power_good_flag),
    .loop_impedance_select(loop_impedance_select),
    .gain_multiplier_select(gain_multiplier_select));
  host_model host_model_i (.pclk(pclk), .apb_rsp(apb_rsp),
    .apb_req(apb_req), .en_in(en_in));

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // Cycles per DAC step at a rate in nV/us
  function automatic int ncyc(input int sel);
    int rates[8] = '{1250000, 2500000, 5000000, 10000000, 78000, 157000,
                     315000, 625000};
    int c;
    c = 1953125000 / rates[sel] / DIV;
    return (c < 1) ? 1 : c;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host_model_i.xfer(1'b1, a, d, rd, err);
  endtask
  task automatic rdreg(input logic [7:0] a);
    host_model_i.xfer(1'b0, a, 32'h0, rd, err);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic rst(input logic [7:0] b, input logic [7:0] r,
                     input code_t p, input logic e);
    @(posedge pclk);
    presetn <= 1'b0;
    boot_strap <= b;
    ramp_strap <= r;
    pre <= p;
    host_model_i.set_en(e);
    cyc(2);
    presetn <= 1'b1;
  endtask
  task automatic wait_pg(output int n);
    n = 0;
    while (power_good_flag !== 1'b1 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    chk("pg_rise", power_good_flag, 1'b1);
  endtask

  task automatic t_start();
    int n;
    rst(8'h01, 8'h1F, '0, 1'b0);
    chk("dac_rst", dac_code, 0);
    cyc(BIAS + 4);
    chk("imp", loop_impedance_select, 2'b11);
    chk("gain", gain_multiplier_select, 1'b1);
    rdreg(ADDR_STAT);
    chk("idle", rd[2:0], 3'h1);
    host_model_i.set_en(1'b1);
    wait_pg(n);
    chk("t_boot", n >= DLY + 64 * ncyc(0) &&
        n <= DLY + 64 * ncyc(0) + 4, 1'b1);
    chk("dac_boot", dac_code, 10'h040);
    cyc(40);
    chk("dac_hold", dac_code, 10'h040);
  endtask

  task automatic t_cmd();
    wr(ADDR_VOUT, 32'h48);
    cyc(8 * ncyc(0) + 4);
    chk("dac_cmd", dac_code, 10'h048);
    wr(ADDR_VOUT, 32'h2C1);
    wr(ADDR_VOUT, 32'h0);
    rdreg(ADDR_STAT);
    chk("bad_cmd", rd[STAT_ERR_BIT], 1'b1);
    chk("st_pg_oe", rd[STAT_OE_BIT:STAT_PG_BIT], 2'b11);
    rdreg(ADDR_DAC);
    chk("dac_keep", rd, 32'h48);
    wr(ADDR_STAT, 32'h100);
    rdreg(ADDR_STAT);
    chk("bad_clr", rd[STAT_ERR_BIT], 1'b0);
    rdreg(8'h10);
    chk("unmapped", err, 1'b1);
    // Override picks the fastest rate: one code per cycle
    wr(ADDR_OVR, 32'hB);
    rdreg(ADDR_OVR);
    chk("ovr", rd, 32'hB);
    wr(ADDR_VOUT, 32'h58);
    cyc(20);
    chk("dac_ovr", dac_code, 10'h058);
  endtask

  task automatic t_abort();
    int n;
    rst(8'hDF, 8'h7F, '0, 1'b1);
    cyc(BIAS - 10);
    rdreg(ADDR_STAT);
    chk("bias", rd[2:0], 3'h0);
    chk("oe_bias", gate_drive_oe, 1'b0);
    n = 0;
    while (dac_code < 10'h030 && n < 500) begin
      @(posedge pclk);
      n++;
    end
    chk("abort_go", n < 500, 1'b1);
    wr(ADDR_VOUT, 32'h50);
    wait_pg(n);
    chk("abort_t", n < 200, 1'b1);
    chk("abort_dac", dac_code, 10'h050);
  endtask

  task automatic t_table();
    logic [7:0] b[6] = '{8'h00, 8'h01, 8'h50, 8'h1F, 8'hE0, 8'h7F};
    code_t v[6] = '{10'h066, 10'h040, 10'h08F, 10'h0AD, 10'h09A, 10'h140};
    int n;
    foreach (b[i]) begin
      rst(b[i], 8'h7F, '0, 1'b0);
      cyc(BIAS + 4);
      host_model_i.set_en(1'b1);
      wait_pg(n);
      chk("boot", dac_code, v[i]);
    end
    rst(8'h01, 8'h7F, '0, 1'b0);
    cyc(BIAS + 4);
    wr(ADDR_VOUT, 32'h90);
    host_model_i.set_en(1'b1);
    wait_pg(n);
    chk("override", dac_code, 10'h090);
    host_model_i.set_en(1'b0);
    cyc(3);
    chk("pg_drop", power_good_flag, 1'b0);
  endtask

  task automatic t_off();
    rst(8'hFF, 8'h7F, '0, 1'b1);
    cyc(BIAS + DLY + 20);
    chk("off_dac", dac_code, 0);
    chk("off_oe", gate_drive_oe, 1'b0);
    rdreg(ADDR_STAT);
    chk("off_st", rd[2:0], 3'h6);
  endtask

  task automatic t_pre();
    code_t p[2] = '{10'h060, 10'h020};
    int n;
    foreach (p[i]) begin
      rst(8'h01, 8'h1F, p[i], 1'b1);
      n = 0;
      while (gate_drive_oe !== 1'b1 && n < 2000) begin
        @(posedge pclk);
        n++;
      end
      chk("pre_oe", gate_drive_oe, 1'b1);
      chk("pre_lvl", dac_code, p[i]);
      wait_pg(n);
      chk("pre_t", n >= 32 * ncyc(0) &&
          n <= 32 * ncyc(0) + 4, 1'b1);
      chk("pre_boot", dac_code, 10'h040);
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Whole run needs well under 12000 cycles
  initial begin
    cyc(40000);
    num_errors++;
    test_done();
  end

  initial begin
    t_start();
    t_cmd();
    t_abort();
    t_table();
    t_off();
    t_pre();
    test_done();
  end
endmodule

// [rtl/ramp_stepper.sv]
// Reference DAC stepper: one code per interval toward a target.
// Assumes interval is at least 1 and target is held while stepping.
module ramp_stepper
  import ssr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire ssr_pkg::code_t load_val,
  input wire ssr_pkg::code_t target,
  input wire logic [ssr_pkg::IVL_W-1:0] interval,
  output ssr_pkg::code_t dac_r,
  output logic at_target
);
  code_t dac_nxt;
  logic [IVL_W-1:0] tick_r;
  logic [IVL_W-1:0] tick_nxt;

  assign at_target = (dac_r == target);

  always_comb begin
    dac_nxt = dac_r;
    tick_nxt = '0;
    if (load) begin
      dac_nxt = load_val;
    end else if (!at_target) begin
      // Step lands exactly on target, never past it
      if (tick_r >= interval - IVL_W'(1)) begin
        dac_nxt = (target > dac_r) ? dac_r + 10'h001 : dac_r - 10'h001;
      end else begin
        tick_nxt = tick_r + IVL_W'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_r <= '0;
      tick_r <= '0;
    end else begin
      dac_r <= dac_nxt;
      tick_r <= tick_nxt;
    end
  end
endmodule

// [rtl/soft_start_ramp_sequencer.sv]
// Soft-start sequencer: bias wait, start delay, boot ramp, command ramps.
// Assumes synchronous straps, enable and precharge level; APB slave.
// Overview of operation
// - Ramp strap top bits pick one of eight slew rates; impedance, gain.
// - Ramp strap: rate bits 7:5, impedance 4:3, gain bit 2.
// - No start before bias timeout of 5.5 ms and enable high.
// - Wait fixed 200 us delay after enable before first ramp.
// - Reference steps digitally toward target at selected slew rate.
// - Hold reference at boot level until a valid command arrives.
// - Valid command ramps reference from present value to command.
// - Command during boot ramp abandons boot target immediately.
// - Precharge: no switching until reference reaches precharge level.
// - Precharge below boot: ramp up to boot, then power good.
// - Precharge above boot, below limit: ramp down, then power good.
// - Boot level comes from 8-bit strap, 256 selections.
// - Boot code maps to command code plus 3Fh, 7.8125 mV steps.
// - Tie-low and tie-high strap codes give popular boot levels.
// - Zero boot level: driver tri-stated, reference held at zero.
// - Command after bias wait and before enable replaces boot level.
//
// Register access over APB and the register addresses were chosen for this implementation.
module soft_start_ramp_sequencer
#(
  parameter int BIAS_CYC = ssr_pkg::BIAS_TIMEOUT_CYC,
  parameter int DELAY_CYC = ssr_pkg::START_DELAY_CYC,
  parameter int SLEW_DIV = 1
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire ssr_pkg::apb_req_t apb_req,
  output ssr_pkg::apb_rsp_t apb_rsp,
  input wire logic en_in,
  input wire logic [7:0] boot_voltage_strap,
  input wire logic [7:0] ramp_config_strap,
  input wire ssr_pkg::code_t precharge_code,
  output ssr_pkg::code_t dac_code,
  output logic gate_drive_oe,
  output logic power_good_flag,
  output logic [1:0] loop_impedance_select,
  output logic gain_multiplier_select
);
  import ssr_pkg::*;

  state_t state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  code_t boot_r, boot_nxt;
  code_t target_r, target_nxt;
  code_t pre_r, pre_nxt;
  logic pg_r, pg_nxt;
  logic oe_r, oe_nxt;
  logic [2:0] rate_r, rate_nxt;
  logic [1:0] imp_r, imp_nxt;
  logic gain_r, gain_nxt;
  logic [3:0] ovr_r, ovr_nxt;
  logic err_r, err_nxt;
  apb_rsp_t rsp_r, rsp_nxt;

  logic setup, access, wr_vout, cmd_ok;
  code_t cmd_code;
  logic stp_load;
  code_t stp_target;
  logic at_target;
  logic [2:0] rate_sel;
  logic [IVL_W-1:0] interval;

  // Bus decode
  assign setup = apb_req.psel & ~apb_req.penable;
  assign access = apb_req.psel & apb_req.penable & rsp_r.pready;
  assign cmd_code = apb_req.pwdata[9:0];
  assign wr_vout = access & apb_req.pwrite & (apb_req.paddr == ADDR_VOUT);
  assign cmd_ok = wr_vout & (cmd_code != '0) & (cmd_code <= CODE_MAX);

  // Override field wins over the strap when enabled
  assign rate_sel = ovr_r[OVR_EN_BIT] ? ovr_r[2:0] : rate_r;
  assign interval = step_cycles(rate_sel, SLEW_DIV);

  // Reference chases the precharge level first, switching held off
  assign stp_target = (state_r == S_PRE) ? pre_r : target_r;
  assign stp_load = (state_r == S_BIAS) || (state_r == S_IDLE) ||
                    (state_r == S_DELAY) || (state_r == S_OFF) ||
                    (state_r == S_FAULT);

  ramp_stepper u_stepper (
    .pclk(pclk),
    .presetn(presetn),
    .load(stp_load),
    .load_val(10'h000),
    .target(stp_target),
    .interval(interval),
    .dac_r(dac_code),
    .at_target(at_target)
  );

  // Sequencer next state
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    boot_nxt = boot_r;
    target_nxt = target_r;
    pre_nxt = pre_r;
    pg_nxt = pg_r;
    oe_nxt = oe_r;
    rate_nxt = rate_r;
    imp_nxt = imp_r;
    gain_nxt = gain_r;
    unique case (state_r)
      S_BIAS: begin
        // Straps are sampled only after release, never under reset
        rate_nxt = ramp_config_strap[RATE_MSB:RATE_LSB];
        imp_nxt = ramp_config_strap[IMP_MSB:IMP_LSB];
        gain_nxt = ramp_config_strap[GAIN_BIT];
        boot_nxt = boot_decode(boot_voltage_strap);
        cnt_nxt = cnt_r + CNT_W'(1);
        if (cnt_r == CNT_W'(BIAS_CYC - 1)) begin
          state_nxt = S_IDLE;
          cnt_nxt = '0;
        end
      end
      S_IDLE: begin
        if (cmd_ok) begin
          boot_nxt = cmd_code;
        end
        if (en_in) begin
          target_nxt = boot_nxt;
          cnt_nxt = '0;
          state_nxt = (boot_nxt == '0) ? S_OFF : S_DELAY;
        end
      end
      S_DELAY: begin
        cnt_nxt = cnt_r + CNT_W'(1);
        if (cmd_ok) begin
          target_nxt = cmd_code;
        end
        if (cnt_r == CNT_W'(DELAY_CYC - 1)) begin
          cnt_nxt = '0;
          pre_nxt = precharge_code;
          if (precharge_code >= OVP_CODE) begin
            state_nxt = S_FAULT;
          end else if (precharge_code != '0) begin
            state_nxt = S_PRE;
          end else begin
            state_nxt = S_RAMP;
            oe_nxt = 1'b1;
          end
        end
      end
      S_PRE: begin
        if (cmd_ok) begin
          target_nxt = cmd_code;
        end
        if (at_target) begin
          // Up or down to the boot level from here
          state_nxt = S_RAMP;
          oe_nxt = 1'b1;
        end
      end
      S_RAMP: begin
        if (cmd_ok) begin
          target_nxt = cmd_code;
        end else if (at_target) begin
          state_nxt = S_HOLD;
          pg_nxt = 1'b1;
        end
      end
      S_HOLD: begin
        if (cmd_ok) begin
          target_nxt = cmd_code;
          state_nxt = S_RAMP;
        end
      end
      S_OFF: begin
        oe_nxt = 1'b0;
      end
      S_FAULT: begin
        // Precharge above the limit: no start until enable cycles
        oe_nxt = 1'b0;
      end
    endcase
    if (state_r != S_BIAS && state_r != S_IDLE && !en_in) begin
      state_nxt = S_IDLE;
      oe_nxt = 1'b0;
      pg_nxt = 1'b0;
      cnt_nxt = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= S_BIAS;
      cnt_r <= '0;
      boot_r <= '0;
      target_r <= '0;
      pre_r <= '0;
      pg_r <= 1'b0;
      oe_r <= 1'b0;
      rate_r <= '0;
      imp_r <= '0;
      gain_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      boot_r <= boot_nxt;
      target_r <= target_nxt;
      pre_r <= pre_nxt;
      pg_r <= pg_nxt;
      oe_r <= oe_nxt;
      rate_r <= rate_nxt;
      imp_r <= imp_nxt;
      gain_r <= gain_nxt;
    end
  end

  // Register slave: data staged in setup, one access cycle, no waits
  always_comb begin
    rsp_nxt = '0;
    ovr_nxt = ovr_r;
    err_nxt = err_r;
    if (setup) begin
      rsp_nxt.pready = 1'b1;
      unique case (apb_req.paddr)
        ADDR_VOUT: rsp_nxt.prdata = {22'h0, target_r};
        ADDR_OVR: rsp_nxt.prdata = {28'h0, ovr_r};
        ADDR_STAT: rsp_nxt.prdata = {23'h0, err_r, 3'h0, oe_r, pg_r,
                                     state_r};
        ADDR_DAC: rsp_nxt.prdata = {22'h0, dac_code};
        default: rsp_nxt.pslverr = 1'b1;
      endcase
    end
    if (access && apb_req.pwrite) begin
      if (apb_req.paddr == ADDR_OVR) begin
        ovr_nxt = apb_req.pwdata[3:0];
      end
      if (apb_req.paddr == ADDR_STAT && apb_req.pwdata[STAT_ERR_BIT]) begin
        err_nxt = 1'b0;
      end
    end
    // A rejected command sets the flag even while it is being cleared
    if (wr_vout && !cmd_ok) begin
      err_nxt = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp_r <= '0;
      ovr_r <= '0;
      err_r <= 1'b0;
    end else begin
      rsp_r <= rsp_nxt;
      ovr_r <= ovr_nxt;
      err_r <= err_nxt;
    end
  end

  assign apb_rsp = rsp_r;
  assign gate_drive_oe = oe_r;
  assign power_good_flag = pg_r;
  assign loop_impedance_select = imp_r;
  assign gain_multiplier_select = gain_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_bias_wait;
    (state_r == S_IDLE && $past(state_r) == S_BIAS)
      |-> $past(cnt_r) == CNT_W'(BIAS_CYC - 1);
  endproperty
  a_bias_wait: assert property (p_bias_wait)
    else $error("bias wait left early");

  property p_start_delay;
    (state_r == S_DELAY && $past(state_r) == S_DELAY && en_in)
      |-> cnt_r <= CNT_W'(DELAY_CYC - 1) && cnt_r == $past(cnt_r) + 1'b1;
  endproperty
  a_start_delay: assert property (p_start_delay)
    else $error("start delay count wrong");

  property p_single_step;
    (!$past(stp_load) && dac_code != $past(dac_code))
      |-> (dac_code == $past(dac_code) + 10'h001 ||
           dac_code == $past(dac_code) - 10'h001);
  endproperty
  a_single_step: assert property (p_single_step)
    else $error("reference moved more than one code");

  property p_hold_level;
    (state_r == S_HOLD) |-> dac_code == target_r && pg_r;
  endproperty
  a_hold_level: assert property (p_hold_level)
    else $error("hold level differs from target");

  property p_off_state;
    (state_r == S_OFF) |-> dac_code == 10'h000 && !oe_r;
  endproperty
  a_off_state: assert property (p_off_state)
    else $error("off state drives output");

  property p_pre_no_switch;
    (state_r == S_PRE) |-> !oe_r && !pg_r;
  endproperty
  a_pre_no_switch: assert property (p_pre_no_switch)
    else $error("switching during precharge ramp");

  property p_cmd_ramp;
    (state_r == S_HOLD && cmd_ok && en_in)
      |=> state_r == S_RAMP && target_r == $past(cmd_code);
  endproperty
  a_cmd_ramp: assert property (p_cmd_ramp)
    else $error("command did not start a ramp");

  property p_abandon_boot;
    (state_r == S_RAMP && !pg_r && cmd_ok && en_in)
      |=> target_r == $past(cmd_code) ##1 state_r != S_HOLD
          || dac_code == target_r;
  endproperty
  a_abandon_boot: assert property (p_abandon_boot)
    else $error("boot target not abandoned");

  property p_boot_override;
    (state_r == S_IDLE && cmd_ok) |=> boot_r == $past(cmd_code);
  endproperty
  a_boot_override: assert property (p_boot_override)
    else $error("command did not replace boot level");

  property p_pg_rise;
    $rose(pg_r) |-> $past(state_r) == S_RAMP && dac_code == target_r;
  endproperty
  a_pg_rise: assert property (p_pg_rise)
    else $error("power good rose before ramp end");
endmodule

// [rtl/ssr_pkg.sv]
// Constants, types and decode helpers of the soft-start ramp sequencer.
// Assumes a 250 MHz pclk and a reference DAC in 7.8125 mV codes.
package ssr_pkg;
  localparam int CLK_MHZ = 250;
  localparam int CNT_W = 21;
  localparam int IVL_W = 16;
  typedef logic [9:0] code_t;
  // Largest legal output command, 5.5 V
  localparam code_t CODE_MAX = 10'h2C0;
  localparam code_t OVP_CODE = 10'h2E0;
  localparam code_t BOOT_OFFSET = 10'h03F;
  localparam int BIAS_TIMEOUT_US = 5500;
  localparam int BIAS_TIMEOUT_CYC = BIAS_TIMEOUT_US * CLK_MHZ;
  localparam int START_DELAY_US = 200;
  localparam int START_DELAY_CYC = START_DELAY_US * CLK_MHZ;
  // One DAC step in nanovolts, so that rates in nV/us divide it directly
  localparam longint STEP_PV = 64'd7812500;
  localparam int RATE_MSB = 7;
  localparam int RATE_LSB = 5;
  localparam int IMP_MSB = 4;
  localparam int IMP_LSB = 3;
  localparam int GAIN_BIT = 2;
  localparam logic [7:0] ADDR_VOUT = 8'h00;
  localparam logic [7:0] ADDR_OVR = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_DAC = 8'h0C;
  localparam int OVR_EN_BIT = 3;
  localparam int STAT_PG_BIT = 3;
  localparam int STAT_OE_BIT = 4;
  localparam int STAT_ERR_BIT = 8;

  typedef enum logic [2:0] {
    S_BIAS = 3'b000,
    S_IDLE = 3'b001,
    S_DELAY = 3'b010,
    S_PRE = 3'b011,
    S_RAMP = 3'b100,
    S_HOLD = 3'b101,
    S_OFF = 3'b110,
    S_FAULT = 3'b111
  } state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

  // Cycles per DAC step; rates in nV/us, result rounded down, at least 1
  function automatic logic [IVL_W-1:0] step_cycles(input logic [2:0] sel,
                                                   input int div);
    longint c;
    c = 64'd1;
    unique case (sel)
      3'd0: c = STEP_PV * CLK_MHZ / 64'd1250000;
      3'd1: c = STEP_PV * CLK_MHZ / 64'd2500000;
      3'd2: c = STEP_PV * CLK_MHZ / 64'd5000000;
      3'd3: c = STEP_PV * CLK_MHZ / 64'd10000000;
      3'd4: c = STEP_PV * CLK_MHZ / 64'd78000;
      3'd5: c = STEP_PV * CLK_MHZ / 64'd157000;
      3'd6: c = STEP_PV * CLK_MHZ / 64'd315000;
      3'd7: c = STEP_PV * CLK_MHZ / 64'd625000;
    endcase
    c = c / longint'(div);
    if (c < 64'd1) begin
      c = 64'd1;
    end
    return c[IVL_W-1:0];
  endfunction

  // Boot strap code to DAC code; tie spots hold popular levels
  function automatic code_t boot_decode(input logic [7:0] s);
    code_t v;
    v = code_t'({2'b00, s}) + BOOT_OFFSET;
    unique case (s)
      8'h00: v = 10'h066;
      8'h20: v = 10'h06D;
      8'h40: v = 10'h073;
      8'h60: v = 10'h07A;
      8'h80: v = 10'h080;
      8'hA0: v = 10'h086;
      8'hC0: v = 10'h08D;
      8'hE0: v = 10'h09A;
      8'h1F: v = 10'h0AD;
      8'h3F: v = 10'h0C0;
      8'h5F: v = 10'h0E6;
      8'h7F: v = 10'h140;
      8'h9F: v = 10'h180;
      8'hBF: v = 10'h1A6;
      8'hDF: v = 10'h280;
      8'hFF: v = 10'h000;
      default: v = code_t'({2'b00, s}) + BOOT_OFFSET;
    endcase
    return v;
  endfunction
endpackage
